// ---- hdl/async_serial_rx_tx_channel.sv ----
// Contract
// - writing transmit data while buffer valid replaces the pending word.
// - interrupt mode may change mid-transfer; last word then ends with end irq.
// - receive channel raises transfer-end interrupt only, never buffer-empty.
// - three error flags; errors raise their own interrupt apart from done.
// - 7, 8 or 9 bit characters; 9-bit word sits in data bits 0 to 8.
// - parity none, zero (not judged), even check or odd check.
// - line polarity selectable; inverted idles low with complemented data.
// - clock select 0 picks prescaler clock zero, 1 prescaler clock one.
// - output level and output enable registers do not affect reception.
// - bit rate is operation clock / (divider+1) / 2.
// - operation clock chosen by prescaler fields and mode bit 15.
`timescale 1ns/10ps
module async_serial_rx_tx_channel (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_serial_rx_pin,
  output logic o_tx_pin,
  output logic o_tx_oe,
  output logic o_irq,
  output logic o_receive_done_irq,
  output logic o_receive_error_irq
);

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP}
    line_state_t;

  function automatic logic presc_tick(input logic [uart_pkg::PRESC_W-1:0] c,
                                      input logic [3:0] k);
    logic [15:0] m;
    m = (16'h0001 << k) - 16'h0001;
    return &(c | ~m[uart_pkg::PRESC_W-1:0]);
  endfunction : presc_tick

  function automatic logic [3:0] len_bits(input uart_pkg::len_t l);
    case (l)
      uart_pkg::LEN_7: len_bits = 4'h7;
      uart_pkg::LEN_9: len_bits = 4'h9;
      default: len_bits = 4'h8;
    endcase
  endfunction : len_bits

  function automatic logic [3:0] bit_pos(input logic [3:0] idx,
                                         input uart_pkg::len_t l,
                                         input logic lsb);
    bit_pos = lsb ? idx : len_bits(l) - 4'h1 - idx;
  endfunction : bit_pos

  uart_pkg::ctrl_t ctrl, next_ctrl;
  logic [uart_pkg::PRESC_W-1:0] presc, next_presc;
  logic [uart_pkg::IRQ_W-1:0] irq_st, next_irq_st;
  logic [31:0] rdata, next_rdata;
  logic slverr, next_slverr;
  logic acc, wr, rd;

  line_state_t tx_state, next_tx_state;
  logic [7:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_idx, next_tx_idx;
  logic [uart_pkg::DATA_W-1:0] tx_buf, next_tx_buf, tx_shift, next_tx_shift;
  logic tx_bff, next_tx_bff, tx_line, next_tx_line, tx_pin, next_tx_pin;
  logic tx_run, tx_optick, tx_bit_end, tx_empty_ev, tx_end_ev, tx_irq_clr;

  line_state_t rx_state, next_rx_state;
  logic [7:0] rx_cnt, next_rx_cnt;
  logic [3:0] rx_idx, next_rx_idx;
  logic [uart_pkg::DATA_W-1:0] rx_shift, next_rx_shift;
  logic [uart_pkg::DATA_W-1:0] rx_data, next_rx_data;
  logic [2:0] rx_flags, next_rx_flags, rx_err;
  logic rx_full, next_rx_full, rx_par, next_rx_par;
  logic rx_s1, rx_s2, rx_bit, rx_run, rx_optick, rx_half_end, rx_full_end;
  logic rx_done_ev;

  // zero-wait APB: read data is latched in the setup cycle
  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;
  assign o_pready = i_penable;
  assign o_prdata = rdata;
  assign o_pslverr = slverr && acc;

  assign tx_run = ctrl.run[0];
  assign rx_run = ctrl.run[1] && ctrl.rx_cfg.rx_en;
  // operation clock enables from the shared prescaler
  assign tx_optick = ctrl.tx_clk_sel ?
    presc_tick(presc, ctrl.presc1_sel) :
    presc_tick(presc, ctrl.presc0_sel);
  assign rx_optick = ctrl.rx_clk_sel ?
    presc_tick(presc, ctrl.presc1_sel) :
    presc_tick(presc, ctrl.presc0_sel);
  // a bit lasts 2*(div+1) operation clocks
  assign tx_bit_end = tx_optick && tx_cnt == {ctrl.tx_div, 1'b1};
  assign rx_full_end = rx_optick && rx_cnt == {ctrl.rx_div, 1'b1};
  assign rx_half_end = rx_optick && rx_cnt == {1'b0, ctrl.rx_div};

  always_comb begin
    next_ctrl = ctrl;
    next_presc = presc + 15'h0001;
    next_slverr = 1'b0;
    next_rdata = 32'h00000000;
    next_irq_st = irq_st;
    if (i_psel && !i_penable) begin
      case (i_paddr)
        uart_pkg::ADDR_PRESCALER:
          next_rdata = {24'h000000, ctrl.presc1_sel, ctrl.presc0_sel};
        uart_pkg::ADDR_TX_MODE: begin
          next_rdata[uart_pkg::MODE_CLK_SEL_BIT] = ctrl.tx_clk_sel;
          next_rdata[uart_pkg::MODE_INV_BIT] = ctrl.tx_inv;
          next_rdata[uart_pkg::MODE_IRQ_MODE_BIT] = ctrl.tx_irq_mode;
        end
        uart_pkg::ADDR_RX_MODE: begin
          next_rdata[uart_pkg::MODE_CLK_SEL_BIT] = ctrl.rx_clk_sel;
          next_rdata[uart_pkg::MODE_INV_BIT] = ctrl.rx_inv;
          next_rdata[uart_pkg::MODE_IRQ_MODE_BIT] = ctrl.rx_irq_mode;
        end
        uart_pkg::ADDR_TX_SETUP: next_rdata = {25'h0000000, ctrl.tx_cfg};
        uart_pkg::ADDR_RX_SETUP: next_rdata = {25'h0000000, ctrl.rx_cfg};
        uart_pkg::ADDR_TX_DATA:
          next_rdata = {16'h0000, ctrl.tx_div, tx_buf};
        uart_pkg::ADDR_RX_DATA:
          next_rdata = {16'h0000, ctrl.rx_div, rx_data};
        uart_pkg::ADDR_TX_STATUS: begin
          next_rdata[uart_pkg::STAT_BFF_BIT] = tx_bff;
          next_rdata[uart_pkg::STAT_BUSY_BIT] = tx_state != ST_IDLE;
        end
        uart_pkg::ADDR_RX_STATUS: begin
          next_rdata[2:0] = rx_flags;
          next_rdata[uart_pkg::STAT_FULL_BIT] = rx_full;
          next_rdata[uart_pkg::STAT_BUSY_BIT] = rx_state != ST_IDLE;
        end
        uart_pkg::ADDR_START, uart_pkg::ADDR_STOP:
          next_rdata = {30'h00000000, ctrl.run};
        uart_pkg::ADDR_OUT_LEVEL: next_rdata = {30'h00000000, ctrl.out_level};
        uart_pkg::ADDR_OUT_ENABLE:
          next_rdata = {30'h00000000, ctrl.out_enable};
        uart_pkg::ADDR_IRQ_STATUS: next_rdata = {29'h00000000, irq_st};
        uart_pkg::ADDR_IRQ_MASK: next_rdata = {29'h00000000, ctrl.irq_mask};
        default: next_slverr = 1'b1;
      endcase
    end else begin
      next_slverr = slverr;
    end
    if (wr) begin
      case (i_paddr)
        uart_pkg::ADDR_PRESCALER: begin
          next_ctrl.presc0_sel = i_pwdata[3:0];
          next_ctrl.presc1_sel = i_pwdata[uart_pkg::PRESC1_LSB +: 4];
        end
        uart_pkg::ADDR_TX_MODE: begin
          next_ctrl.tx_clk_sel = i_pwdata[uart_pkg::MODE_CLK_SEL_BIT];
          next_ctrl.tx_inv = i_pwdata[uart_pkg::MODE_INV_BIT];
          // accepted at any time, also mid-frame
          next_ctrl.tx_irq_mode = i_pwdata[uart_pkg::MODE_IRQ_MODE_BIT];
        end
        uart_pkg::ADDR_RX_MODE: begin
          next_ctrl.rx_clk_sel = i_pwdata[uart_pkg::MODE_CLK_SEL_BIT];
          next_ctrl.rx_inv = i_pwdata[uart_pkg::MODE_INV_BIT];
          next_ctrl.rx_irq_mode = i_pwdata[uart_pkg::MODE_IRQ_MODE_BIT];
        end
        uart_pkg::ADDR_TX_SETUP:
          next_ctrl.tx_cfg = uart_pkg::cfg_t'(i_pwdata[6:0]);
        uart_pkg::ADDR_RX_SETUP:
          next_ctrl.rx_cfg = uart_pkg::cfg_t'(i_pwdata[6:0]);
        uart_pkg::ADDR_TX_DATA:
          next_ctrl.tx_div = i_pwdata[uart_pkg::DIV_LSB +: uart_pkg::DIV_W];
        uart_pkg::ADDR_RX_DATA:
          next_ctrl.rx_div = i_pwdata[uart_pkg::DIV_LSB +: uart_pkg::DIV_W];
        uart_pkg::ADDR_START: next_ctrl.run = ctrl.run | i_pwdata[1:0];
        uart_pkg::ADDR_STOP: next_ctrl.run = ctrl.run & ~i_pwdata[1:0];
        uart_pkg::ADDR_OUT_LEVEL: next_ctrl.out_level = i_pwdata[1:0];
        uart_pkg::ADDR_OUT_ENABLE: next_ctrl.out_enable = i_pwdata[1:0];
        uart_pkg::ADDR_IRQ_STATUS:
          next_irq_st = irq_st & ~i_pwdata[uart_pkg::IRQ_W-1:0];
        uart_pkg::ADDR_IRQ_MASK:
          next_ctrl.irq_mask = i_pwdata[uart_pkg::IRQ_W-1:0];
        default: next_irq_st = irq_st;
      endcase
    end
    // events win over a clear in the same cycle
    next_irq_st[uart_pkg::IRQ_TX] = next_irq_st[uart_pkg::IRQ_TX] |
                                    tx_empty_ev | tx_end_ev;
    // receive channel never raises buffer-empty; mode bit is ignored
    next_irq_st[uart_pkg::IRQ_RX_DONE] =
      next_irq_st[uart_pkg::IRQ_RX_DONE] | rx_done_ev;
    next_irq_st[uart_pkg::IRQ_RX_ERR] =
      next_irq_st[uart_pkg::IRQ_RX_ERR] | (rx_done_ev && |rx_err);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl <= '{tx_cfg: uart_pkg::CFG_RESET, rx_cfg: uart_pkg::CFG_RESET,
                out_level: uart_pkg::OUT_LEVEL_RESET, default: '0};
      presc <= '0;
      irq_st <= '0;
      rdata <= '0;
      slverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      presc <= next_presc;
      irq_st <= next_irq_st;
      rdata <= next_rdata;
      slverr <= next_slverr;
    end
  end

  assign o_irq = |(irq_st & ctrl.irq_mask);
  assign o_receive_done_irq = irq_st[uart_pkg::IRQ_RX_DONE] &&
                              ctrl.irq_mask[uart_pkg::IRQ_RX_DONE];
  assign o_receive_error_irq = irq_st[uart_pkg::IRQ_RX_ERR] &&
                               ctrl.irq_mask[uart_pkg::IRQ_RX_ERR];

  // transmitter
  always_comb begin
    next_tx_state = tx_state;
    next_tx_cnt = tx_cnt;
    next_tx_idx = tx_idx;
    next_tx_shift = tx_shift;
    next_tx_line = tx_line;
    next_tx_buf = tx_buf;
    next_tx_bff = tx_bff;
    tx_empty_ev = 1'b0;
    tx_end_ev = 1'b0;
    if (tx_state != ST_IDLE && tx_optick)
      next_tx_cnt = tx_bit_end ? 8'h00 : tx_cnt + 8'h01;
    case (tx_state)
      ST_IDLE: begin
        next_tx_line = 1'b1;
        if (tx_run && tx_bff) begin
          next_tx_shift = tx_buf;
          next_tx_bff = 1'b0;
          next_tx_state = ST_START;
          next_tx_cnt = 8'h00;
          next_tx_line = 1'b0;
          tx_empty_ev = ctrl.tx_irq_mode;
        end
      end
      ST_START: if (tx_bit_end) begin
        next_tx_state = ST_DATA;
        next_tx_idx = 4'h0;
        next_tx_line = tx_shift[bit_pos(4'h0, ctrl.tx_cfg.len,
                                        ctrl.tx_cfg.lsb_first)];
      end
      ST_DATA: if (tx_bit_end) begin
        if (tx_idx == len_bits(ctrl.tx_cfg.len) - 4'h1) begin
          next_tx_idx = 4'h0;
          case (ctrl.tx_cfg.parity)
            uart_pkg::PAR_NONE: begin
              next_tx_state = ST_STOP;
              next_tx_line = 1'b1;
            end
            uart_pkg::PAR_ZERO: begin
              next_tx_state = ST_PAR;
              next_tx_line = 1'b0;
            end
            uart_pkg::PAR_EVEN: begin
              next_tx_state = ST_PAR;
              next_tx_line = ^(tx_shift & ~(9'h1FF <<
                               len_bits(ctrl.tx_cfg.len)));
            end
            default: begin
              next_tx_state = ST_PAR;
              next_tx_line = ~^(tx_shift & ~(9'h1FF <<
                                len_bits(ctrl.tx_cfg.len)));
            end
          endcase
        end else begin
          next_tx_idx = tx_idx + 4'h1;
          next_tx_line = tx_shift[bit_pos(tx_idx + 4'h1, ctrl.tx_cfg.len,
                                          ctrl.tx_cfg.lsb_first)];
        end
      end
      ST_PAR: if (tx_bit_end) begin
        next_tx_state = ST_STOP;
        next_tx_idx = 4'h0;
        next_tx_line = 1'b1;
      end
      ST_STOP: if (tx_bit_end) begin
        if (ctrl.tx_cfg.stop2 && tx_idx == 4'h0) begin
          next_tx_idx = 4'h1;
        end else begin
          next_tx_state = ST_IDLE;
          // mode bit read live, so a late switch still ends with this
          tx_end_ev = !ctrl.tx_irq_mode;
        end
      end
      default: next_tx_state = ST_IDLE;
    endcase
    if (!tx_run) begin
      next_tx_state = ST_IDLE;
      next_tx_line = 1'b1;
    end
    // a new word replaces a pending unsent one
    if (wr && i_paddr == uart_pkg::ADDR_TX_DATA) begin
      next_tx_buf = i_pwdata[uart_pkg::DATA_W-1:0];
      next_tx_bff = 1'b1;
    end
    // idle high, or low with data complemented when inverted
    next_tx_pin = tx_run ? next_tx_line ^ ctrl.tx_inv :
                  ctrl.out_level[0];
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_state <= ST_IDLE;
      tx_cnt <= '0;
      tx_idx <= '0;
      tx_shift <= '0;
      tx_buf <= '0;
      tx_bff <= 1'b0;
      tx_line <= 1'b1;
      tx_pin <= 1'b1;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      tx_idx <= next_tx_idx;
      tx_shift <= next_tx_shift;
      tx_buf <= next_tx_buf;
      tx_bff <= next_tx_bff;
      tx_line <= next_tx_line;
      tx_pin <= next_tx_pin;
    end
  end

  assign o_tx_pin = tx_pin;
  assign o_tx_oe = ctrl.out_enable[0];

  // receiver; pin sampled through two flops, output registers unused here
  assign rx_bit = rx_s2 ^ ctrl.rx_inv;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt = rx_cnt;
    next_rx_idx = rx_idx;
    next_rx_shift = rx_shift;
    next_rx_par = rx_par;
    next_rx_data = rx_data;
    next_rx_flags = rx_flags;
    next_rx_full = rx_full;
    rx_done_ev = 1'b0;
    rx_err = 3'h0;
    if (rx_state != ST_IDLE && rx_optick)
      next_rx_cnt = rx_full_end ? 8'h00 : rx_cnt + 8'h01;
    case (rx_state)
      ST_IDLE: if (!rx_bit) begin
        next_rx_state = ST_START;
        next_rx_cnt = 8'h00;
      end
      ST_START: if (rx_half_end) begin
        next_rx_cnt = 8'h00;
        next_rx_idx = 4'h0;
        next_rx_par = 1'b0;
        next_rx_shift = '0;
        next_rx_state = rx_bit ? ST_IDLE : ST_DATA;
      end
      ST_DATA: if (rx_full_end) begin
        next_rx_shift[bit_pos(rx_idx, ctrl.rx_cfg.len,
                              ctrl.rx_cfg.lsb_first)] = rx_bit;
        next_rx_par = rx_par ^ rx_bit;
        next_rx_idx = rx_idx + 4'h1;
        if (rx_idx == len_bits(ctrl.rx_cfg.len) - 4'h1)
          next_rx_state = ctrl.rx_cfg.parity == uart_pkg::PAR_NONE ?
                          ST_STOP : ST_PAR;
      end
      ST_PAR: if (rx_full_end) begin
        next_rx_par = rx_par ^ rx_bit;
        next_rx_state = ST_STOP;
      end
      ST_STOP: if (rx_full_end) begin
        rx_done_ev = 1'b1;
        rx_err[uart_pkg::STAT_FE_BIT] = !rx_bit;
        rx_err[uart_pkg::STAT_OVF_BIT] = rx_full;
        // zero parity is taken but never judged
        rx_err[uart_pkg::STAT_PE_BIT] =
          (ctrl.rx_cfg.parity == uart_pkg::PAR_EVEN && rx_par) ||
          (ctrl.rx_cfg.parity == uart_pkg::PAR_ODD && !rx_par);
        next_rx_data = rx_shift;
        next_rx_state = ST_IDLE;
      end
      default: next_rx_state = ST_IDLE;
    endcase
    if (!rx_run)
      next_rx_state = ST_IDLE;
    if (rd && i_paddr == uart_pkg::ADDR_RX_DATA)
      next_rx_full = 1'b0;
    if (wr && i_paddr == uart_pkg::ADDR_RX_STATUS)
      next_rx_flags = rx_flags & ~i_pwdata[2:0];
    next_rx_flags = next_rx_flags | rx_err;
    next_rx_full = next_rx_full | rx_done_ev;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_state <= ST_IDLE;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_shift <= '0;
      rx_par <= 1'b0;
      rx_data <= '0;
      rx_flags <= '0;
      rx_full <= 1'b0;
    end else begin
      rx_s1 <= i_serial_rx_pin;
      rx_s2 <= rx_s1;
      rx_state <= next_rx_state;
      rx_cnt <= next_rx_cnt;
      rx_idx <= next_rx_idx;
      rx_shift <= next_rx_shift;
      rx_par <= next_rx_par;
      rx_data <= next_rx_data;
      rx_flags <= next_rx_flags;
      rx_full <= next_rx_full;
    end
  end

  property p_overwrite;
    @(posedge i_clock) disable iff (i_rst)
    (wr && i_paddr == uart_pkg::ADDR_TX_DATA) |=>
      tx_bff && tx_buf == $past(i_pwdata[8:0]);
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("transmit word not replaced");

  // a stop that aborts the frame is no transfer end
  assign tx_irq_clr = wr && i_paddr == uart_pkg::ADDR_IRQ_STATUS &&
                      i_pwdata[uart_pkg::IRQ_TX];

  property p_tx_irq_kind;
    @(posedge i_clock) disable iff (i_rst)
    (tx_state == ST_STOP && next_tx_state == ST_IDLE && tx_run) |=>
      irq_st[uart_pkg::IRQ_TX] == (!$past(ctrl.tx_irq_mode) ||
        ($past(irq_st[uart_pkg::IRQ_TX]) && !$past(tx_irq_clr)));
  endproperty
  a_tx_irq_kind: assert property (p_tx_irq_kind)
    else $error("end interrupt does not follow live mode bit");

  property p_rx_done_only;
    @(posedge i_clock) disable iff (i_rst)
    $rose(irq_st[uart_pkg::IRQ_RX_DONE]) |-> $past(rx_state) == ST_STOP;
  endproperty
  a_rx_done_only: assert property (p_rx_done_only)
    else $error("receive interrupt outside frame end");

  property p_err_irq;
    @(posedge i_clock) disable iff (i_rst)
    (rx_done_ev && |rx_err) |=>
      irq_st[uart_pkg::IRQ_RX_ERR] && (rx_flags & $past(rx_err)) != 3'h0;
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("receive error not flagged");

  property p_rx_word;
    @(posedge i_clock) disable iff (i_rst)
    rx_done_ev |=> rx_full && rx_data == $past(rx_shift);
  endproperty
  a_rx_word: assert property (p_rx_word)
    else $error("received word not stored");

  property p_zero_par;
    @(posedge i_clock) disable iff (i_rst)
    (rx_done_ev && ctrl.rx_cfg.parity inside
      {uart_pkg::PAR_NONE, uart_pkg::PAR_ZERO}) |-> !rx_err[1];
  endproperty
  a_zero_par: assert property (p_zero_par)
    else $error("parity judged in no-check mode");

  property p_idle_level;
    @(posedge i_clock) disable iff (i_rst)
    (tx_run && tx_state == ST_IDLE && !tx_bff) |=>
      o_tx_pin == !$past(ctrl.tx_inv);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("wrong idle line level");

  property p_bit_count;
    @(posedge i_clock) disable iff (i_rst)
    (tx_run && tx_state != ST_IDLE && tx_optick && !tx_bit_end) |=>
      tx_cnt == $past(tx_cnt) + 8'h01;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("bit timer not advancing");

  property p_fe;
    @(posedge i_clock) disable iff (i_rst)
    (rx_state == ST_STOP && rx_full_end && !rx_bit && rx_run) |=>
      rx_flags[uart_pkg::STAT_FE_BIT];
  endproperty
  a_fe: assert property (p_fe)
    else $error("framing error missed");

endmodule : async_serial_rx_tx_channel

// ---- hdl/uart_pkg.sv ----
package uart_pkg;

  localparam int DATA_W = 9;
  localparam int DIV_W = 7;
  localparam int PRESC_W = 15;
  localparam int IRQ_W = 3;

  // register byte addresses
  localparam logic [11:0] ADDR_PRESCALER = 12'h000;
  localparam logic [11:0] ADDR_TX_MODE = 12'h004;
  localparam logic [11:0] ADDR_RX_MODE = 12'h008;
  localparam logic [11:0] ADDR_TX_SETUP = 12'h00C;
  localparam logic [11:0] ADDR_RX_SETUP = 12'h010;
  localparam logic [11:0] ADDR_TX_DATA = 12'h014;
  localparam logic [11:0] ADDR_RX_DATA = 12'h018;
  localparam logic [11:0] ADDR_TX_STATUS = 12'h01C;
  localparam logic [11:0] ADDR_RX_STATUS = 12'h020;
  localparam logic [11:0] ADDR_START = 12'h024;
  localparam logic [11:0] ADDR_STOP = 12'h028;
  localparam logic [11:0] ADDR_OUT_LEVEL = 12'h02C;
  localparam logic [11:0] ADDR_OUT_ENABLE = 12'h030;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h034;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h038;

  // field positions
  localparam int MODE_CLK_SEL_BIT = 15;
  localparam int MODE_INV_BIT = 6;
  localparam int MODE_IRQ_MODE_BIT = 0;
  localparam int DIV_LSB = 9;
  localparam int PRESC1_LSB = 4;
  localparam int STAT_BFF_BIT = 0;
  localparam int STAT_BUSY_BIT = 6;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_PE_BIT = 1;
  localparam int STAT_FE_BIT = 2;
  localparam int STAT_FULL_BIT = 5;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX_DONE = 1;
  localparam int IRQ_RX_ERR = 2;

  typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_EVEN, PAR_ODD} parity_t;
  typedef enum logic [1:0] {LEN_7, LEN_8, LEN_9, LEN_RSV} len_t;

  typedef struct packed {
    logic rx_en;
    logic stop2;
    logic lsb_first;
    parity_t parity;
    len_t len;
  } cfg_t;

  typedef struct packed {
    logic [3:0] presc0_sel;
    logic [3:0] presc1_sel;
    logic tx_clk_sel;
    logic tx_irq_mode;
    logic tx_inv;
    logic rx_clk_sel;
    logic rx_irq_mode;
    logic rx_inv;
    cfg_t tx_cfg;
    cfg_t rx_cfg;
    logic [DIV_W-1:0] tx_div;
    logic [DIV_W-1:0] rx_div;
    logic [1:0] run;
    logic [1:0] out_level;
    logic [1:0] out_enable;
    logic [IRQ_W-1:0] irq_mask;
  } ctrl_t;

  localparam cfg_t CFG_RESET = 7'h01;
  localparam logic [1:0] OUT_LEVEL_RESET = 2'h3;

endpackage : uart_pkg

// ---- verif/remote_serial.sv ----
`timescale 1ns/10ps
module remote_serial #(parameter int BIT = 6) (
  input wire logic i_clock,
  input wire logic i_tx_pin,
  output logic o_line
);
  logic inv = 1'b0;
  initial o_line = 1'b1;
  task automatic set_inv(input logic v);
    inv = v;
    o_line <= ~v;
  endtask : set_inv
  task automatic send(input logic [12:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      o_line <= f[i] ^ inv;
      repeat (BIT) @(posedge i_clock);
    end
    o_line <= ~inv;
  endtask : send
  task automatic catch_word(output logic [8:0] w);
    w = '0;
    @(negedge i_tx_pin);
    repeat (BIT / 2) @(posedge i_clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_clock);
      w[i] = i_tx_pin;
    end
  endtask : catch_word
endmodule : remote_serial

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: %h not %h", $time, a, b); end end
module tb_top;
  logic i_clock = 0, i_rst = 1, psel = 0, pen = 0, pwr = 0, slv, p;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, r;
  logic pready, pslverr, rx_line, tx_pin, tx_oe, irq, done_irq, err_irq;
  logic [8:0] d, w1, w2;
  logic [12:0] f;
  int n_mismatch = 0, compares = 0, cyc = 0, n, len, par;
  int exp_q[$];
  integer seed = 32'h24ad;
  always #2 i_clock = ~i_clock;
  async_serial_rx_tx_channel DUT (.i_clock(i_clock), .i_rst(i_rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(pslverr),
    .i_serial_rx_pin(rx_line), .o_tx_pin(tx_pin), .o_tx_oe(tx_oe),
    .o_irq(irq), .o_receive_done_irq(done_irq),
    .o_receive_error_irq(err_irq));
  remote_serial #(.BIT(6)) peer (.i_clock(i_clock), .i_tx_pin(tx_pin),
    .o_line(rx_line));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge i_clock);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= v;
    @(posedge i_clock);
    pen <= 1;
    do @(posedge i_clock); while (pready !== 1'b1);
    r = prd; slv = pslverr;
    psel <= 0; pen <= 0;
  endtask : apb
  task automatic init_rx(input logic [31:0] ps, input logic [31:0] md);
    apb(1, uart_pkg::ADDR_PRESCALER, ps);
    apb(1, uart_pkg::ADDR_TX_MODE, md);
    apb(1, uart_pkg::ADDR_RX_MODE, md);
    apb(1, uart_pkg::ADDR_RX_SETUP, 32'h51);
    repeat (4) @(posedge i_clock);
    apb(1, uart_pkg::ADDR_RX_DATA, 32'h400);
    apb(1, uart_pkg::ADDR_START, 32'h2);
  endtask : init_rx
  task automatic rx_case(input int i, input bit bp, input bit bs, input bit ov,
                         input bit keep);
    len = 7 + i % 3; par = i % 4;
    d = 9'($random(seed)) & 9'((1 << len) - 1);
    p = (par == 1) ? 1'b0 : (par == 2) ? ^d : ~^d;
    f = '0; n = 1 + len;
    for (int k = 0; k < len; k++) f[1 + k] = d[k];
    if (par != 0) begin
      f[n] = p ^ bp; n++;
    end
    f[n] = ~bs; n++;
    apb(1, uart_pkg::ADDR_IRQ_MASK, i ? 32'h7 : 32'h0);
    apb(1, uart_pkg::ADDR_RX_SETUP, 32'(32'h50 | (par << 2) | (len - 7)));
    peer.send(f, n);
    for (int k = 0; k < 40; k++) begin
      apb(0, uart_pkg::ADDR_RX_STATUS, 0);
      if (r[5]) break;
    end
    `CHK(r[2:0], {bs, bp && par >= 2, ov})
    `CHK(err_irq, (bs || (bp && par >= 2) || ov) && i != 0)
    `CHK(done_irq, i != 0)
    `CHK(irq, i != 0)
    if (!keep) begin
      apb(0, uart_pkg::ADDR_RX_DATA, 0);
      `CHK(r[8:0], d)
      apb(1, uart_pkg::ADDR_RX_STATUS, 32'h7);
      apb(1, uart_pkg::ADDR_IRQ_STATUS, 32'h7);
    end
    $display("test rx %0d done", i);
  endtask : rx_case
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 0;
    @(posedge i_clock);
    `CHK({tx_pin, tx_oe}, 2'b10)
    apb(0, uart_pkg::ADDR_OUT_LEVEL, 0);
    `CHK(r[1:0], 2'h3)
    apb(0, 12'h03C, 0);
    `CHK({slv, r}, 33'h100000000)
    init_rx(32'h0, 32'h0);
    for (int i = 0; i < 6; i++) rx_case(i, i[0], i == 5, 0, 0);
    rx_case(1, 0, 0, 0, 1);
    rx_case(2, 0, 0, 1, 0);
    apb(1, uart_pkg::ADDR_TX_SETUP, 32'h11);
    apb(1, uart_pkg::ADDR_START, 32'h1);
    fork
      begin
        peer.catch_word(w1);
        peer.catch_word(w2);
      end
      for (int k = 0; k < 3; k++) begin
        d = 9'($random(seed)) & 9'hFF;
        if (k != 1) exp_q.push_back(int'(d));
        apb(1, uart_pkg::ADDR_TX_DATA, 32'(d) | 32'h400);
      end
    join
    `CHK(w1, 9'(exp_q[0]))
    `CHK(w2, 9'(exp_q[1]))
    $display("test tx done");
    // let the last frame finish, reset, then set up afresh
    repeat (20) @(posedge i_clock);
    i_rst <= 1;
    repeat (5) @(posedge i_clock);
    i_rst <= 0;
    @(posedge i_clock);
    `CHK({tx_pin, tx_oe, irq}, 3'b100)
    peer.set_inv(1);
    // clock one at full rate, clock zero at half: wrong pick breaks timing
    init_rx(32'h1, 32'h8040);
    rx_case(3, 1, 0, 0, 0);
    $display("test reset done");
    report_and_stop();
  end
endmodule : tb_top
